// File: acs_pkg.sv
// Constants shared by the converter control end and the host end.
// Assumes a single 10 MHz clock and an asynchronous active-high reset.
// Overview of operation
// - Fast low, lowpower high: low-power mode
// - Host keeps low-power rate at most 450 kSPS
// - Low-power mode powers down after each conversion
// - Coding choice except in full-width parallel
// - Coding from pin or configuration register
// - Register control ignores coding pin; host drives it from the same bit
// - Zero input: 0x20000 binary, 0x00000 twos
// - Top saturates 0x3FFFF binary, 0x1FFFF twos
// - Bottom saturates 0x00000 binary, 0x20000 twos
// - Hardware modes take span from select pins
// - Register span ignores span pins; host drives them from the same bits
// - Fast high, lowpower low: fast mode, 670 kSPS
// - Equal mode pins: normal mode, 570 kSPS
// - Conversion starts after acquisition on start low
// - Finished approximation gives code, busy low
package acs_pkg;
   localparam int RES_BITS = 18;
   localparam logic [17:0] CODE_MID = 18'h20000;
   localparam logic [17:0] CODE_TOP = 18'h3FFFF;
   localparam logic [17:0] CODE_ZERO = 18'h00000;
   localparam logic [17:0] MSB_MASK = 18'h20000;
   localparam int CLK_HZ = 10000000;
   localparam int RATE_FAST_SPS = 670000;
   localparam int RATE_NORMAL_SPS = 570000;
   localparam int RATE_LOWPWR_SPS = 450000;
   // Least cycle time per conversion, rounded up
   localparam int PERIOD_FAST_CYC = (CLK_HZ + RATE_FAST_SPS - 1) / RATE_FAST_SPS;
   localparam int PERIOD_NORMAL_CYC = (CLK_HZ + RATE_NORMAL_SPS - 1) / RATE_NORMAL_SPS;
   localparam int PERIOD_LOWPWR_CYC = (CLK_HZ + RATE_LOWPWR_SPS - 1) / RATE_LOWPWR_SPS;
   localparam int ACQ_CYC = 4;
   localparam logic [4:0] ACQ_CNT = 5'(ACQ_CYC);
   localparam logic [4:0] PER_FAST = 5'(PERIOD_FAST_CYC);
   localparam logic [4:0] PER_NORMAL = 5'(PERIOD_NORMAL_CYC);
   localparam logic [4:0] PER_LOWPWR = 5'(PERIOD_LOWPWR_CYC);
   localparam logic [4:0] SAR_STEPS = 5'(RES_BITS);
   // Host register map
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_SAMPLE = 4'h1;
   localparam logic [3:0] REG_RESULT = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam int CTRL_FAST = 0;
   localparam int CTRL_LOWPWR = 1;
   localparam int CTRL_TWOS = 2;
   localparam int CTRL_SIGNED = 3;
   localparam int CTRL_HIGH = 4;
   localparam int CTRL_REGCFG = 5;
   localparam int CTRL_WIDE = 6;
   localparam int CTRL_START = 7;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   typedef enum logic [1:0] {ACS_NORMAL, ACS_FAST, ACS_LOWPWR} acs_mode_e;
   typedef enum logic [1:0] {ACS_UNI5, ACS_UNI10, ACS_BIP5, ACS_BIP10} acs_span_e;
endpackage

// File: acs_link_if.sv
// Pins between converter control and host.
// Assumes both ends share core_clk.
`timescale 1ns/10ps
interface acs_link_if;
   logic fast_mode_select;
   logic low_power_mode_select;
   logic coding_select_pin;
   logic signed_range_select;
   logic high_span_select;
   logic conversion_start_n;
   logic reg_cfg_valid;
   logic [6:0] reg_cfg;
   logic wide_parallel;
   logic [17:0] sample_in;
   logic busy;
   logic [17:0] result;
   logic powered;
   modport device (
      input fast_mode_select, low_power_mode_select, coding_select_pin,
      input signed_range_select, high_span_select, conversion_start_n,
      input reg_cfg_valid, reg_cfg, wide_parallel, sample_in,
      output busy, result, powered
   );
   modport host (
      output fast_mode_select, low_power_mode_select, coding_select_pin,
      output signed_range_select, high_span_select, conversion_start_n,
      output reg_cfg_valid, reg_cfg, wide_parallel, sample_in,
      input busy, result, powered
   );
endinterface

// File: acs_code_fmt.sv
// Result coding: saturation and binary or twos complement form.
// Assumes a signed offset input scaled by the caller's span; clamped here.
`timescale 1ns/10ps
module acs_code_fmt (
   input wire logic [18:0] raw_signed, // Signed sample, beyond range allowed
   input wire logic twos, // Twos complement requested
   output logic [17:0] code // Formatted code
);
   logic [17:0] straight;
   always_comb
   begin
      // Sample is offset from midscale; saturate at both ends
      if ($signed(raw_signed) >= $signed({1'b0, acs_pkg::CODE_TOP ^ acs_pkg::MSB_MASK}))
      begin
         straight = acs_pkg::CODE_TOP;
      end
      else if ($signed(raw_signed) <= $signed({1'b1, acs_pkg::MSB_MASK}))
      begin
         straight = acs_pkg::CODE_ZERO;
      end
      else
      begin
         straight = raw_signed[17:0] ^ acs_pkg::MSB_MASK;
      end
      code = twos ? (straight ^ acs_pkg::MSB_MASK) : straight;
   end
endmodule

// File: acs_device.sv
// Converter control end: mode, span and coding selection, conversion timing.
// Assumes pins synchronous to core_clk; sample_in models the analog value.
`timescale 1ns/10ps
module acs_device (
   input wire logic core_clk, // 10 MHz clock
   input wire logic sys_rst, // Async reset, active high
   acs_link_if.device link, // Pins to host
   output logic [1:0] mode, // Active conversion mode
   output logic [1:0] span // Active input span
);
   typedef enum logic [1:0] {ST_ACQ, ST_READY, ST_CONV} acs_state_e;
   acs_state_e state, next_state;
   logic [4:0] cnt, next_cnt;
   logic [17:0] result, next_result;
   logic busy, next_busy, powered, next_powered;
   logic [6:0] cfg, next_cfg;
   logic [1:0] mode_q, next_mode, span_q, next_span;
   logic start_d, next_start_d;
   logic [18:0] held, next_held;
   logic sel_fast, sel_lowpwr, sel_twos, sel_signed, sel_high;
   logic [18:0] scaled;
   logic [17:0] fmt_code;
   logic start_fall;

   ////////////////////////////////////////////////////////////////////
   // Source select: register overrides pins when it holds control
   always_comb
   begin
      next_cfg = link.reg_cfg_valid ? link.reg_cfg : cfg;
      if (cfg[acs_pkg::CTRL_REGCFG])
      begin
         sel_fast = cfg[acs_pkg::CTRL_FAST];
         sel_lowpwr = cfg[acs_pkg::CTRL_LOWPWR];
         sel_twos = cfg[acs_pkg::CTRL_TWOS];
         sel_signed = cfg[acs_pkg::CTRL_SIGNED];
         sel_high = cfg[acs_pkg::CTRL_HIGH];
      end
      else
      begin
         sel_fast = link.fast_mode_select;
         sel_lowpwr = link.low_power_mode_select;
         sel_twos = link.coding_select_pin;
         sel_signed = link.signed_range_select;
         sel_high = link.high_span_select;
      end
      // Full-width parallel output carries straight binary only
      if (link.wide_parallel)
      begin
         sel_twos = 1'b0;
      end
      if (sel_fast && !sel_lowpwr)
      begin
         next_mode = acs_pkg::ACS_FAST;
      end
      else if (!sel_fast && sel_lowpwr)
      begin
         next_mode = acs_pkg::ACS_LOWPWR;
      end
      else
      begin
         next_mode = acs_pkg::ACS_NORMAL;
      end
      next_span = {sel_signed, sel_high};
      // Mode and span stay frozen while a conversion runs; coding does not
      if (state == ST_CONV)
      begin
         next_mode = mode_q;
         next_span = span_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Span scaling: unipolar spans sit half a range higher
   always_comb
   begin
      if (span_q[1])
      begin
         scaled = held;
      end
      else
      begin
         // Held sample is sign-extended; unipolar spans use the raw bits
         scaled = 19'({1'b0, held[17:0]} - {1'b0, acs_pkg::CODE_MID});
      end
   end

   acs_code_fmt i_acs_code_fmt (
      .raw_signed(scaled),
      .twos(sel_twos),
      .code(fmt_code)
   );

   ////////////////////////////////////////////////////////////////////
   // Start edge detect; resets high, the idle level, so no false edge
   always_comb
   begin
      next_start_d = link.conversion_start_n;
      start_fall = start_d && !link.conversion_start_n;
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         start_d <= 1'b1;
      end
      else
      begin
         start_d <= next_start_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Conversion sequencer
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_result = result;
      next_busy = busy;
      next_powered = powered;
      next_held = held;
      case (state)
         ST_ACQ:
         begin
            // Starts seen before acquisition completes are dropped
            if (cnt == acs_pkg::ACQ_CNT)
            begin
               next_state = ST_READY;
            end
            else
            begin
               next_cnt = 5'(cnt + 5'h01);
            end
         end
         ST_READY:
         begin
            // Falling edge after acquisition samples and converts
            if (start_fall)
            begin
               next_state = ST_CONV;
               next_held = {link.sample_in[17], link.sample_in};
               next_busy = 1'b1;
               next_powered = 1'b1;
               next_cnt = 5'h00;
            end
         end
         default:
         begin
            if (cnt == acs_pkg::SAR_STEPS)
            begin
               next_state = ST_ACQ;
               next_result = fmt_code;
               next_busy = 1'b0;
               next_cnt = 5'h00;
               // Low-power mode drops the converter until the next start
               next_powered = (mode_q != acs_pkg::ACS_LOWPWR);
            end
            else
            begin
               next_cnt = 5'(cnt + 5'h01);
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= ST_ACQ;
         cnt <= 5'h00;
         result <= 18'h00000;
         busy <= 1'b0;
         powered <= 1'b1;
         held <= 19'h00000;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         result <= next_result;
         busy <= next_busy;
         powered <= next_powered;
         held <= next_held;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Settings registers; the select logic holds mode and span during conversion
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cfg <= 7'h00;
         mode_q <= 2'h0;
         span_q <= 2'h0;
      end
      else
      begin
         cfg <= next_cfg;
         mode_q <= next_mode;
         span_q <= next_span;
      end
   end

   assign link.busy = busy;
   assign link.result = result;
   assign link.powered = powered;
   assign mode = mode_q;
   assign span = span_q;
endmodule

// File: acs_host.sv
// Host end: drives select pins and configuration, paces conversions.
// Assumes software on a plain register port, read data one cycle later.
`timescale 1ns/10ps
module acs_host (
   input wire logic core_clk, // 10 MHz clock
   input wire logic sys_rst, // Async reset, active high
   acs_link_if.host link, // Pins to device
   input wire logic [3:0] addr, // Register address
   input wire logic [31:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [31:0] rdata // Read data
);
   logic [31:0] ctrl, next_ctrl, next_rdata;
   logic [17:0] sample, next_sample, res, next_res;
   logic pend, next_pend, cfg_v, next_cfg_v, start_n, next_start_n, busy_d;
   logic [4:0] gap, next_gap, period;
   // Wait after reset or busy falling, so the device has reacquired
   localparam logic [4:0] ACQ_WAIT = 5'(acs_pkg::ACQ_CNT + 5'h01);

   always_comb
   begin
      // Pacing per mode; the low-power limit is the tightest
      if (ctrl[acs_pkg::CTRL_FAST] && !ctrl[acs_pkg::CTRL_LOWPWR])
      begin
         period = acs_pkg::PER_FAST;
      end
      else if (!ctrl[acs_pkg::CTRL_FAST] && ctrl[acs_pkg::CTRL_LOWPWR])
      begin
         period = acs_pkg::PER_LOWPWR;
      end
      else
      begin
         period = acs_pkg::PER_NORMAL;
      end
      next_ctrl = ctrl;
      next_sample = sample;
      next_res = res;
      next_pend = pend;
      next_cfg_v = 1'b0;
      next_start_n = 1'b1;
      next_gap = (gap != 5'h00) ? 5'(gap - 5'h01) : gap;
      next_rdata = 32'h00000000;
      if (wr && addr == acs_pkg::REG_CTRL)
      begin
         next_ctrl = wdata & 32'h0000007F;
         next_cfg_v = 1'b1;
         next_pend = pend | wdata[acs_pkg::CTRL_START];
      end
      else if (wr && addr == acs_pkg::REG_SAMPLE)
      begin
         next_sample = wdata[17:0];
      end
      if (rd && addr == acs_pkg::REG_CTRL)
      begin
         next_rdata = ctrl;
      end
      else if (rd && addr == acs_pkg::REG_SAMPLE)
      begin
         next_rdata = {14'h0000, sample};
      end
      else if (rd && addr == acs_pkg::REG_RESULT)
      begin
         next_rdata = {14'h0000, res};
      end
      else if (rd && addr == acs_pkg::REG_STATUS)
      begin
         next_rdata = {29'h00000000, link.powered, pend, link.busy};
      end
      // Start only when idle and the rate spacing has passed
      if (pend && gap == 5'h00 && !link.busy && !busy_d)
      begin
         next_start_n = 1'b0;
         next_pend = 1'b0;
         next_gap = period;
      end
      if (busy_d && !link.busy)
      begin
         next_res = link.result;
         // A start during reacquisition would be dropped and lost
         if (gap < ACQ_WAIT)
         begin
            next_gap = ACQ_WAIT;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl <= acs_pkg::CTRL_RESET;
         sample <= 18'h00000;
         res <= 18'h00000;
         pend <= 1'b0;
         cfg_v <= 1'b0;
         start_n <= 1'b1;
         gap <= ACQ_WAIT;
         busy_d <= 1'b0;
         rdata <= 32'h00000000;
      end
      else
      begin
         ctrl <= next_ctrl;
         sample <= next_sample;
         res <= next_res;
         pend <= next_pend;
         cfg_v <= next_cfg_v;
         start_n <= next_start_n;
         gap <= next_gap;
         busy_d <= link.busy;
         rdata <= next_rdata;
      end
   end

   // Pins carry the same settings, also while the register controls
   assign link.fast_mode_select = ctrl[acs_pkg::CTRL_FAST];
   assign link.low_power_mode_select = ctrl[acs_pkg::CTRL_LOWPWR];
   assign link.coding_select_pin = ctrl[acs_pkg::CTRL_TWOS];
   assign link.signed_range_select = ctrl[acs_pkg::CTRL_SIGNED];
   assign link.high_span_select = ctrl[acs_pkg::CTRL_HIGH];
   assign link.conversion_start_n = start_n;
   assign link.reg_cfg_valid = cfg_v;
   assign link.reg_cfg = ctrl[6:0];
   assign link.wide_parallel = ctrl[acs_pkg::CTRL_WIDE];
   assign link.sample_in = sample;
endmodule

// File: acs_link_asserts.sv
// Concurrent checks on the link between converter control and host.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/10ps
module acs_link_asserts (
   input wire logic core_clk, // Clock
   input wire logic sys_rst, // Reset, active high
   input wire logic fast_mode_select, // Mode pin
   input wire logic low_power_mode_select, // Mode pin
   input wire logic signed_range_select, // Span pin
   input wire logic high_span_select, // Span pin
   input wire logic conversion_start_n, // Start, active low
   input wire logic reg_cfg_valid, // Config strobe
   input wire logic [6:0] reg_cfg, // Config word
   input wire logic busy, // Converting
   input wire logic [17:0] result, // Output code
   input wire logic powered, // Power state
   input wire logic [1:0] mode, // Device mode
   input wire logic [1:0] span // Device span
);
   logic [4:0] busy_cnt;
   logic [4:0] next_busy_cnt;
   logic [5:0] gap;
   logic [5:0] next_gap;
   logic [6:0] cfg_q;
   logic [6:0] next_cfg_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
////////////////////////////////////////////////////////////////
   // Gap saturates so a long idle never wraps into a false short one
   always_comb
   begin
      next_busy_cnt = busy ? busy_cnt + 5'h01 : 5'h00;
      next_gap = !conversion_start_n ? 6'h01 : (gap == 6'h3F ? gap : gap + 6'h01);
      next_cfg_q = reg_cfg_valid ? reg_cfg : cfg_q;
   end
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy_cnt <= 5'h00;
         gap <= 6'h3F;
         cfg_q <= 7'h00;
      end
      else
      begin
         busy_cnt <= next_busy_cnt;
         gap <= next_gap;
         cfg_q <= next_cfg_q;
      end
   end
////////////////////////////////////////////////////////////////
   start_busy_a: assert property (
      $rose(busy) |-> !$past(conversion_start_n) && $past(conversion_start_n, 2))
      else $error("busy rose without a start edge");
   busy_len_a: assert property (
      $fell(busy) |-> busy_cnt == 5'(acs_pkg::SAR_STEPS + 5'h01))
      else $error("conversion length wrong");
   result_hold_a: assert property ($changed(result) |-> $fell(busy))
      else $error("result changed outside completion");
   power_after_a: assert property (
      $fell(busy) |-> powered == (mode != acs_pkg::ACS_LOWPWR))
      else $error("power state after conversion wrong");
   busy_power_a: assert property (busy |-> powered)
      else $error("unpowered during conversion");
   mode_pins_a: assert property (
      (!busy && !cfg_q[5] && $stable({fast_mode_select, low_power_mode_select}))[*3]
      |-> mode == {!fast_mode_select && low_power_mode_select,
      fast_mode_select && !low_power_mode_select})
      else $error("mode does not follow pins");
   span_pins_a: assert property (
      (!busy && !cfg_q[5] && $stable({signed_range_select, high_span_select}))[*3]
      |-> span == {signed_range_select, high_span_select})
      else $error("span does not follow pins");
   reg_span_a: assert property (
      (!busy && cfg_q[5] && $stable(cfg_q))[*3]
      |-> span == {cfg_q[3], cfg_q[4]}
      && mode == {!cfg_q[0] && cfg_q[1], cfg_q[0] && !cfg_q[1]})
      else $error("register settings not applied");
   lowpwr_pace_a: assert property (
      $fell(conversion_start_n) && mode == acs_pkg::ACS_LOWPWR
      |-> gap >= {1'b0, acs_pkg::PER_LOWPWR})
      else $error("low-power starts too close");
endmodule

// File: adc_mode_range_code_select_tb_top.sv
// Bench: conversions driven through the host register port across the link.
// Assumes both design ends joined by the link interface on one clock.
`timescale 1ns/10ps
module adc_mode_range_code_select_tb_top;
   logic core_clk;
   logic sys_rst;
   logic [3:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic [31:0] got;
   logic [1:0] mode;
   logic [1:0] span;
   int bad_count;
   int checks_done;
   logic [7:0] t_ctrl [11] = '{8'h80, 8'h84, 8'h81, 8'h85, 8'h82, 8'h86, 8'h88, 8'hBC, 8'hC4,
      8'h83, 8'h9C};
   logic [17:0] t_smp [11] = '{18'h20000, 18'h20000, 18'h3FFFF, 18'h3FFFF, 18'h00000, 18'h00000,
      18'h00000, 18'h1FFFF, 18'h20001, 18'h1FFFF, 18'h20000};
   logic [17:0] t_exp [11] = '{18'h20000, 18'h00000, 18'h3FFFF, 18'h1FFFF, 18'h00000, 18'h20000,
      18'h20000, 18'h1FFFF, 18'h20001, 18'h1FFFF, 18'h20000};
   acs_link_if link ();
   acs_host i_acs_host (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   acs_device i_acs_device (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .mode(mode),
      .span(span));
   acs_link_asserts i_acs_link_asserts (.core_clk(core_clk), .sys_rst(sys_rst),
      .fast_mode_select(link.fast_mode_select), .low_power_mode_select(link.low_power_mode_select),
      .signed_range_select(link.signed_range_select), .high_span_select(link.high_span_select),
      .conversion_start_n(link.conversion_start_n), .reg_cfg_valid(link.reg_cfg_valid),
      .reg_cfg(link.reg_cfg), .busy(link.busy), .result(link.result), .powered(link.powered),
      .mode(mode), .span(span));
////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // A spare edge after each access keeps strobe edges in separate time steps
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge core_clk);
   endtask
   task automatic conv(input logic [7:0] c, input logic [17:0] s, input logic [17:0] e);
      logic [31:0] st;
      logic seen;
      logic [1:0] em;
      seen = 1'b0;
      em = (c[1:0] == 2'b01) ? 2'h1 : ((c[1:0] == 2'b10) ? 2'h2 : 2'h0);
      wr_reg(acs_pkg::REG_SAMPLE, {14'h0000, s});
      wr_reg(acs_pkg::REG_CTRL, {24'h000000, c});
      for (int i = 0; i < 60; i++)
      begin
         rd_reg(acs_pkg::REG_STATUS, st);
         if (st[0])
            seen = 1'b1;
         else if (seen && !st[1])
            break;
      end
      if (!seen || st[0] !== 1'b0)
      begin
         bad_count++;
         $display("mismatch at %0t: conversion never completed", $time);
         end_sim();
      end
      chk({31'h0, st[2]}, {31'h0, c[1:0] != 2'b10}, "powered");
      chk({30'h0, mode}, {30'h0, em}, "mode");
      chk({30'h0, span}, {30'h0, c[3], c[4]}, "span");
      rd_reg(acs_pkg::REG_RESULT, st);
      chk(st, {14'h0000, e}, "result");
   endtask
////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever
         #50 core_clk = ~core_clk;
   end
   initial
   begin
      sys_rst = 1'b1;
      addr = 4'h0;
      wdata = 32'h00000000;
      wr = 1'b0;
      rd = 1'b0;
      bad_count = 0;
      checks_done = 0;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      wr_reg(4'hF, 32'hFFFFFFFF);
      rd_reg(4'hF, got);
      chk(got, 32'h00000000, "unmapped read");
      rd_reg(acs_pkg::REG_CTRL, got);
      chk(got, acs_pkg::CTRL_RESET, "ctrl reset");
      $display("test registers done");
      for (int i = 0; i < 11; i++)
      begin
         conv(t_ctrl[i], t_smp[i], t_exp[i]);
         $display("test conversion %0d done", i);
      end
      rd_reg(acs_pkg::REG_SAMPLE, got);
      chk(got, 32'h00020000, "sample readback");
      // Reset in mid-conversion must leave a clean, idle link
      wr_reg(acs_pkg::REG_CTRL, 32'h00000081);
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      rd_reg(acs_pkg::REG_STATUS, got);
      chk({31'h0, got[0]}, 32'h00000000, "busy after reset");
      conv(8'h80, 18'h20000, 18'h20000);
      $display("test reset recovery done");
      end_sim();
   end
endmodule
